// ---- watchdog_and_reset_control.sv ----
// watchdog timer, keyed enables and reset sequencing behind an AHB-Lite slave
module watchdog_and_reset_control #(
    parameter int unsigned POR_CYCLES   = wdt_pkg::POR_DELAY_CYC,
    parameter int unsigned START_CYCLES = wdt_pkg::START_DELAY_CYC,
    parameter int unsigned SRESET_CNT   = wdt_pkg::SRESET_TICKS,
    parameter int unsigned LOW_SPEED_RC_CLOCK_CYCLES  = wdt_pkg::LOW_SPEED_RC_CLOCK_DIV
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire wdt_pkg::ahb_req_t ahb_req,
    output wdt_pkg::ahb_rsp_t      ahb_rsp,
    input  wire logic              clear_instr,
    input  wire logic              halt_instr,
    input  wire logic              low_power_mode,
    input  wire logic              external_init_pin_n,
    output wdt_pkg::reset_out_t    rst_out
);
    import wdt_pkg::*;

    localparam logic [DLY_W-1:0] POR_LOAD   = DLY_W'(POR_CYCLES - 1);
    localparam logic [DLY_W-1:0] START_LOAD = DLY_W'(START_CYCLES - 1);
    localparam logic [DLY_W-1:0] SRST_LOAD  = DLY_W'(SRESET_CNT - 1);

    logic low_speed_rc_clock_tick;
    logic pin_s;

    // low_speed_rc_clock modelled as an enable from the system clock
    tick_divider #(
        .DIV (LOW_SPEED_RC_CLOCK_CYCLES)
    ) u_low_speed_rc_clock (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (low_speed_rc_clock_tick)
    );

    pin_sync u_pin (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .pin_async  (external_init_pin_n),
        .pin_stable (pin_s)
    );

    // bus state
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [3:0]  wr_addr_q;
    logic [3:0]  wr_addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rd_flags_q;
    logic        rd_flags_d;

    // core state
    rst_state_t          state_q;
    rst_state_t          state_d;
    logic [DLY_W-1:0]    dly_q;
    logic [DLY_W-1:0]    dly_d;
    logic [WDT_BITS-1:0] cnt_q;
    logic [WDT_BITS-1:0] cnt_d;
    logic [7:0]          ctrl_q;
    logic [7:0]          ctrl_d;
    logic [7:0]          pinkey_q;
    logic [7:0]          pinkey_d;
    logic [3:0]          flags_q;
    logic [3:0]          flags_d;
    logic                to_q;
    logic                to_d;
    logic                pdf_q;
    logic                pdf_d;
    logic                fault_pin_q;
    logic                fault_pin_d;
    reset_out_t          out_q;
    reset_out_t          out_d;

    logic                addr_ok;
    logic                addr_hit;
    logic                wr_ctrl;
    logic                wr_flags;
    logic                wr_pinkey;
    logic [4:0]          key;
    logic                key_bad;
    logic                pinkey_bad;
    logic                wdt_on;
    logic                pin_rst_req;
    logic                ovf;
    logic [WDT_BITS-1:0] mask;

    function automatic logic [31:0] read_reg(input logic [3:0] a, input logic [7:0] c,
                                             input logic [3:0] f, input logic [7:0] p,
                                             input logic t, input logic d);
        logic [31:0] r;
        r = 32'h0;
        unique case (a)
            OFS_CTRL:   r[7:0] = c;
            OFS_FLAGS:  r[3:0] = f;
            OFS_PINKEY: r[7:0] = p;
            OFS_STATUS: r[1:0] = {d, t};
            default:    r = 32'h0;
        endcase
        return r;
    endfunction

    assign addr_ok    = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    assign addr_hit   = (ahb_req.haddr[31:4] == 28'h0) && (ahb_req.haddr[1:0] == 2'h0);
    assign wr_ctrl    = wr_pend_q && (wr_addr_q == OFS_CTRL);
    assign wr_flags   = wr_pend_q && (wr_addr_q == OFS_FLAGS);
    assign wr_pinkey  = wr_pend_q && (wr_addr_q == OFS_PINKEY);
    assign key        = ctrl_q[KEY_LSB +: 5];
    assign key_bad    = (key != KEY_ENABLE) && (key != KEY_DISABLE);
    assign pinkey_bad = (pinkey_q != PINKEY_IO) && (pinkey_q != PINKEY_RES);
    assign wdt_on     = (key == KEY_ENABLE);
    assign pin_rst_req = (pinkey_q == PINKEY_RES) && !pin_s;
    assign mask       = tap_mask(ctrl_q[2:0]);
    assign ovf        = low_speed_rc_clock_tick && wdt_on && (state_q == ST_RUN)
                        && ((cnt_q & mask) == mask);

    always_comb begin
        state_d     = state_q;
        dly_d       = dly_q;
        cnt_d       = cnt_q;
        ctrl_d      = ctrl_q;
        pinkey_d    = pinkey_q;
        flags_d     = flags_q;
        to_d        = to_q;
        pdf_d       = pdf_q;
        fault_pin_d = fault_pin_q;
        out_d       = '0;
        // software writes only while the core runs; only hardware sets a flag
        if (state_q == ST_RUN) begin
            if (wr_ctrl) begin
                ctrl_d = ahb_req.hwdata[7:0];
            end
            if (wr_pinkey) begin
                pinkey_d = ahb_req.hwdata[7:0];
            end
            if (wr_flags) begin
                flags_d[FLAG_KEY]    = flags_q[FLAG_KEY] & ahb_req.hwdata[FLAG_KEY];
                flags_d[FLAG_PINKEY] = flags_q[FLAG_PINKEY] & ahb_req.hwdata[FLAG_PINKEY];
            end
        end
        if (low_speed_rc_clock_tick && wdt_on && (state_q == ST_RUN)) begin
            cnt_d = WDT_BITS'(cnt_q + 1'b1);
        end
        unique case (state_q)
            ST_POR_WAIT: begin
                if (dly_q == '0) begin
                    state_d = ST_RUN;
                end else begin
                    dly_d = DLY_W'(dly_q - 1'b1);
                end
            end
            ST_RUN: begin
                if (pin_rst_req) begin
                    state_d = ST_PIN_HOLD;
                    cnt_d   = '0;
                end else if (key_bad || pinkey_bad) begin
                    state_d     = ST_SW_DELAY;
                    dly_d       = SRST_LOAD;
                    fault_pin_d = !key_bad;
                    cnt_d       = '0;
                end else if (ovf) begin
                    to_d  = 1'b1;
                    cnt_d = '0;
                    if (low_power_mode) begin
                        out_d.pc_sp_clear = 1'b1;
                        out_d.wake        = 1'b1;
                    end else begin
                        state_d  = ST_START_WAIT;
                        dly_d    = START_LOAD;
                        ctrl_d   = CTRL_POR;
                        pinkey_d = PINKEY_IO;
                    end
                end else begin
                    if (clear_instr) begin
                        cnt_d = '0;
                        pdf_d = 1'b0;
                    end
                    if (halt_instr) begin
                        cnt_d = '0;
                        pdf_d = 1'b1;
                        to_d  = 1'b0;
                    end
                end
            end
            ST_SW_DELAY: begin
                cnt_d = '0;
                if (low_speed_rc_clock_tick) begin
                    if (dly_q == '0) begin
                        state_d  = ST_START_WAIT;
                        dly_d    = START_LOAD;
                        ctrl_d   = CTRL_POR;
                        pinkey_d = PINKEY_IO;
                        if (fault_pin_q) begin
                            flags_d[FLAG_PINKEY] = 1'b1;
                        end else begin
                            flags_d[FLAG_KEY] = 1'b1;
                        end
                    end else begin
                        dly_d = DLY_W'(dly_q - 1'b1);
                    end
                end
            end
            ST_PIN_HOLD: begin
                cnt_d = '0;
                if (pin_s) begin
                    state_d  = ST_START_WAIT;
                    dly_d    = START_LOAD;
                    ctrl_d   = CTRL_POR;
                    pinkey_d = PINKEY_IO;
                end
            end
            ST_START_WAIT: begin
                if (dly_q == '0) begin
                    state_d = ST_RUN;
                end else begin
                    dly_d = DLY_W'(dly_q - 1'b1);
                end
            end
        endcase
        out_d.core_reset    = (state_d == ST_POR_WAIT) || (state_d == ST_PIN_HOLD)
                              || (state_d == ST_START_WAIT);
        out_d.port_preset   = (state_d == ST_POR_WAIT);
        out_d.regs_preserve = out_d.core_reset && !out_d.port_preset;
        out_d.pin_is_io     = (pinkey_d != PINKEY_RES);
    end

    // read data taken from next-state values so a write just before is seen
    always_comb begin
        wr_pend_d  = addr_ok && ahb_req.hwrite && addr_hit;
        wr_addr_d  = ahb_req.haddr[3:0];
        rd_flags_d = addr_ok && !ahb_req.hwrite && addr_hit
                     && (ahb_req.haddr[3:0] == OFS_FLAGS);
        rdata_d    = rdata_q;
        if (addr_ok && !ahb_req.hwrite) begin
            rdata_d = addr_hit ? read_reg(ahb_req.haddr[3:0], ctrl_d, flags_d,
                                          pinkey_d, to_d, pdf_d) : 32'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q     <= ST_POR_WAIT;
            dly_q       <= POR_LOAD;
            cnt_q       <= '0;
            ctrl_q      <= CTRL_POR;
            pinkey_q    <= PINKEY_IO;
            flags_q     <= 4'h0;
            to_q        <= 1'b0;
            pdf_q       <= 1'b0;
            fault_pin_q <= 1'b0;
            out_q       <= '{core_reset: 1'b1, port_preset: 1'b1, pin_is_io: 1'b1,
                             default: 1'b0};
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 4'h0;
            rdata_q     <= 32'h0;
            rd_flags_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            dly_q       <= dly_d;
            cnt_q       <= cnt_d;
            ctrl_q      <= ctrl_d;
            pinkey_q    <= pinkey_d;
            flags_q     <= flags_d;
            to_q        <= to_d;
            pdf_q       <= pdf_d;
            fault_pin_q <= fault_pin_d;
            out_q       <= out_d;
            wr_pend_q   <= wr_pend_d;
            wr_addr_q   <= wr_addr_d;
            rdata_q     <= rdata_d;
            rd_flags_q  <= rd_flags_d;
        end
    end

    assign rst_out = out_q;
    assign ahb_rsp = '{hrdata: rdata_q, hreadyout: 1'b1, hresp: 1'b0};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_fault_seen;
        (state_q == ST_RUN) && !pin_rst_req && key_bad;
    endsequence
    sequence s_delay_done;
        (state_q == ST_SW_DELAY) && low_speed_rc_clock_tick && (dly_q == '0) && !fault_pin_q;
    endsequence

    property p_count_on_tick;
        !low_speed_rc_clock_tick |=> (cnt_q == '0) || $stable(cnt_q);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick)
        else $error("watchdog count moved without a low-speed tick");

    property p_key_fault;
        s_fault_seen |=> (state_q == ST_SW_DELAY) && (cnt_q == '0) && !rst_out.core_reset;
    endproperty
    a_key_fault: assert property (p_key_fault)
        else $error("invalid key did not start the reset delay");

    property p_fault_flag;
        s_delay_done |=> flags_q[FLAG_KEY] && rst_out.core_reset && (ctrl_q == CTRL_POR);
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("key fault reset did not set the flag");

    property p_flag_sticky;
        flags_q[FLAG_KEY] && !wr_flags |=> flags_q[FLAG_KEY];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("key fault flag cleared without a write");

    property p_flags_upper;
        rd_flags_q |-> (ahb_rsp.hrdata[31:4] == 28'h0);
    endproperty
    a_flags_upper: assert property (p_flags_upper)
        else $error("unimplemented flag bits read nonzero");

    property p_ovf_run;
        ovf && !low_power_mode && !pin_rst_req && !key_bad && !pinkey_bad
            |=> rst_out.core_reset && to_q && (cnt_q == '0);
    endproperty
    a_ovf_run: assert property (p_ovf_run)
        else $error("running overflow did not reset the device");

    property p_ovf_sleep;
        ovf && low_power_mode && !pin_rst_req && !key_bad && !pinkey_bad
            |=> rst_out.pc_sp_clear && rst_out.wake && to_q && !rst_out.core_reset
                ##1 !rst_out.pc_sp_clear;
    endproperty
    a_ovf_sleep: assert property (p_ovf_sleep)
        else $error("sleeping overflow did not give a one-cycle partial reset");

    property p_halt;
        (state_q == ST_RUN) && halt_instr && !ovf && !pin_rst_req && !key_bad && !pinkey_bad
            |=> pdf_q && !to_q && (cnt_q == '0);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt did not set power-down and clear timeout");

    property p_clear;
        (state_q == ST_RUN) && clear_instr && !halt_instr && !ovf && !pin_rst_req
            && !key_bad && !pinkey_bad |=> !pdf_q && (cnt_q == '0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear instruction did not clear count and power-down");

    property p_pin_reset;
        (state_q == ST_RUN) && pin_rst_req |=> rst_out.core_reset && rst_out.regs_preserve
            && (state_q == ST_PIN_HOLD);
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("low reset pin did not hold the core in reset");

    property p_start_hold;
        (state_q == ST_START_WAIT) && (dly_q != '0) |=> rst_out.core_reset;
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("core released before start-up delay ended");

    property p_por;
        $fell(reset) |-> rst_out.core_reset && rst_out.port_preset [*8];
    endproperty
    a_por: assert property (p_por)
        else $error("power-on delay or port preset not held");

endmodule // watchdog_and_reset_control

// ---- wdt_pkg.sv ----
// constants, field layouts and carrier types of the watchdog and reset controller
//
// Overview of operation
// - watchdog counts only low-speed RC clock ticks
// - period select picks tap 2^8 to 2^18
// - key 01010B enables, 10101B disables, else reset
// - control powers up with key enabled, select 011
// - invalid key reset sets key fault flag
// - key fault flag set by hardware, cleared by zero
// - upper four flag bits read as zero
// - running overflow resets device, sets timeout flag
// - sleeping overflow sets timeout, clears PC and SP only
// - key fault, clear, halt, pin reset clear count
// - pin key selects I/O, reset pin, else reset
// - pin key powers up selecting general I/O
// - low reset pin resets device, PC to zero
// - pin reset preserves a defined register subset
// - start-up delay after reset pin release
// - power-on delay before execution starts
// - power-on presets ports so pins are inputs
// - halt sets power-down, clears timeout and count
// - power-up or clear instruction clears power-down flag
// - sleeping overflow wakes device, sets timeout flag
package wdt_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned LOW_SPEED_RC_CLOCK_HZ         = 32_000;
    localparam int unsigned LOW_SPEED_RC_CLOCK_DIV        = CLK_HZ / LOW_SPEED_RC_CLOCK_HZ;
    localparam int unsigned POR_DELAY_MS    = 48;
    localparam int unsigned START_DELAY_MS  = 16;
    localparam int unsigned POR_DELAY_CYC   = POR_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned START_DELAY_CYC = START_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned SRESET_TICKS    = 4;
    localparam int unsigned DLY_W           = 20;
    localparam int unsigned WDT_BITS        = 18;

    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_FLAGS  = 4'h4;
    localparam logic [3:0] OFS_PINKEY = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam int unsigned KEY_LSB     = 3;
    localparam logic [4:0]  KEY_ENABLE  = 5'h0A;
    localparam logic [4:0]  KEY_DISABLE = 5'h15;
    localparam logic [7:0]  CTRL_POR    = 8'h53;
    localparam logic [7:0]  PINKEY_IO   = 8'h55;
    localparam logic [7:0]  PINKEY_RES  = 8'hAA;
    localparam int unsigned FLAG_KEY    = 0;
    localparam int unsigned FLAG_PINKEY = 3;
    localparam int unsigned STAT_TO     = 0;
    localparam int unsigned STAT_PDF    = 1;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic core_reset;
        logic pc_sp_clear;
        logic wake;
        logic port_preset;
        logic regs_preserve;
        logic pin_is_io;
    } reset_out_t;

    typedef enum logic [2:0] {
        ST_POR_WAIT, ST_RUN, ST_SW_DELAY, ST_PIN_HOLD, ST_START_WAIT
    } rst_state_t;

    // overflow mask for the selected period
    function automatic logic [WDT_BITS-1:0] tap_mask(input logic [2:0] sel);
        logic [WDT_BITS-1:0] m;
        m = '0;
        unique case (sel)
            3'h0: m = 18'h000FF;
            3'h1: m = 18'h003FF;
            3'h2: m = 18'h00FFF;
            3'h3: m = 18'h03FFF;
            3'h4: m = 18'h07FFF;
            3'h5: m = 18'h0FFFF;
            3'h6: m = 18'h1FFFF;
            3'h7: m = 18'h3FFFF;
        endcase
        return m;
    endfunction

endpackage

// ---- tick_divider.sv ----
// divider making the low-speed clock tick as a one-cycle enable
module tick_divider #(
    parameter int unsigned DIV = 625
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_d;

    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d  = tick_d ? '0 : W'(cnt_q + 1'b1);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule // tick_divider

// ---- pin_sync.sv ----
// three-stage synchroniser; the output moves once stages two and three agree
module pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin_async,
    output logic      pin_stable
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       stable_d;

    always_comb begin
        sync_d   = {sync_q[1:0], pin_async};
        stable_d = (sync_q[2] == sync_q[1]) ? sync_q[1] : pin_stable;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_q     <= 3'h7;
            pin_stable <= 1'b1;
        end else begin
            sync_q     <= sync_d;
            pin_stable <= stable_d;
        end
    end
endmodule // pin_sync

// ---- watchdog_and_reset_control_tb_top.sv ----
// self-checking testbench of the watchdog and reset controller
module watchdog_and_reset_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    logic                clk_sys;
    logic                reset;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [31:0]         hwdata;
    logic                clear_instr;
    logic                halt_instr;
    logic                low_power_mode;
    logic                external_init_pin_n;
    ahb_req_t            req;
    ahb_rsp_t            rsp;
    reset_out_t          rst_out;
    int                  mismatches;
    int                  tests_run;
    int                  cycles;
    int                  n;

    assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                   hsize: 3'h2, hwdata: hwdata, hready: rsp.hreadyout};

    watchdog_and_reset_control #(
        .POR_CYCLES   (20),
        .START_CYCLES (10),
        .SRESET_CNT   (2),
        .LOW_SPEED_RC_CLOCK_CYCLES  (4)
    ) dut (
        .clk_sys             (clk_sys),
        .reset               (reset),
        .ahb_req             (req),
        .ahb_rsp             (rsp),
        .clear_instr         (clear_instr),
        .halt_instr          (halt_instr),
        .low_power_mode      (low_power_mode),
        .external_init_pin_n (external_init_pin_n),
        .rst_out             (rst_out)
    );

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one single-word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x, exp, msg);
    endtask

    task automatic instr(input logic is_halt);
        if (is_halt) halt_instr <= 1'b1;
        else clear_instr <= 1'b1;
        @(posedge clk_sys);
        halt_instr  <= 1'b0;
        clear_instr <= 1'b0;
    endtask

    // counts cycles until core_reset shows lvl, giving up at lim
    task automatic wait_rst(input logic lvl, input int lim, output int k);
        k = 0;
        while (k < lim && rst_out.core_reset !== lvl) begin
            @(posedge clk_sys);
            k++;
        end
    endtask

    task automatic t_power_on();
        check(rst_out.port_preset, 1'b1, "port preset during power-on");
        check(rst_out.pc_sp_clear, 1'b0, "no partial reset at power-on");
        check(rst_out.wake, 1'b0, "no wake pulse at power-on");
        check(rsp.hresp, 1'b0, "bus response okay");
        wait_rst(1'b0, 100, n);
        check(n >= 18 && n <= 24, 1'b1, "power-on delay length");
        rd_chk(32'h0, 32'h53, "control reset value");
        rd_chk(32'h4, 32'h0, "flags reset value");
        rd_chk(32'h8, 32'h55, "pin key reset value");
        check(rst_out.pin_is_io, 1'b1, "pin starts as I/O");
        rd_chk(32'hC, 32'h0, "status after power-on");
        rd_chk(32'h10, 32'h0, "unmapped read");
    endtask

    task automatic t_overflow_run();
        wr(32'h0, {24'h0, KEY_ENABLE, 3'h0});
        instr(1'b0);
        wait_rst(1'b1, 1100, n);
        check(n >= 1000 && n <= 1040, 1'b1, "overflow at 2^8 ticks");
        wait_rst(1'b0, 40, n);
        rd_chk(32'hC, 32'h1, "timeout flag after overflow");
        rd_chk(32'h0, 32'h53, "control restored");
        wr(32'h0, {24'h0, KEY_ENABLE, 3'h1});
        instr(1'b0);
        wait_rst(1'b1, 4200, n);
        check(n >= 4080 && n <= 4120, 1'b1, "overflow at 2^10 ticks");
        wait_rst(1'b0, 40, n);
    endtask

    task automatic t_halt_sleep();
        instr(1'b1);
        rd_chk(32'hC, 32'h2, "halt sets power-down clears timeout");
        wr(32'h0, {24'h0, KEY_ENABLE, 3'h0});
        low_power_mode <= 1'b1;
        instr(1'b1);
        n = 0;
        while (n < 1100 && rst_out.pc_sp_clear !== 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        check(n >= 1000 && n <= 1040, 1'b1, "sleep overflow time");
        check(rst_out.wake, 1'b1, "wake with pc clear");
        check(rst_out.core_reset, 1'b0, "no full reset in sleep");
        low_power_mode <= 1'b0;
        rd_chk(32'hC, 32'h3, "timeout and power-down set");
        instr(1'b0);
        rd_chk(32'hC, 32'h1, "clear drops power-down");
    endtask

    task automatic t_clear_and_disable();
        instr(1'b0);
        repeat (10) begin
            wait_rst(1'b1, 200, n);
            check(n, 200, "periodic clear holds off reset");
            instr(1'b0);
        end
        wr(32'h0, {24'h0, KEY_DISABLE, 3'h0});
        wait_rst(1'b1, 1500, n);
        check(n, 1500, "disabled watchdog never fires");
    endtask

    task automatic t_key_fault();
        wr(32'h0, 32'hF8);
        wait_rst(1'b1, 40, n);
        check(n < 40, 1'b1, "bad enable key resets");
        wait_rst(1'b0, 40, n);
        rd_chk(32'h4, 32'h1, "key fault flag set");
        wr(32'h4, 32'h1);
        rd_chk(32'h4, 32'h1, "writing one keeps flag");
        wr(32'h4, 32'h0);
        rd_chk(32'h4, 32'h0, "writing zero clears flag");
        wr(32'h8, 32'h12);
        wait_rst(1'b1, 40, n);
        wait_rst(1'b0, 40, n);
        rd_chk(32'h4, 32'h8, "pin key fault flag");
    endtask

    task automatic t_pin_reset();
        wr(32'h8, {24'h0, PINKEY_RES});
        @(posedge clk_sys);
        check(rst_out.pin_is_io, 1'b0, "reset function selected");
        external_init_pin_n <= 1'b0;
        wait_rst(1'b1, 10, n);
        check(n < 10, 1'b1, "low pin resets core");
        check(rst_out.regs_preserve, 1'b1, "warm reset preserves");
        check(rst_out.port_preset, 1'b0, "no port preset on warm reset");
        repeat (20) @(posedge clk_sys);
        external_init_pin_n <= 1'b1;
        wait_rst(1'b0, 40, n);
        check(n >= 10 && n <= 20, 1'b1, "start-up delay after release");
        rd_chk(32'h8, 32'h55, "pin key back to I/O");
    endtask

    initial begin
        reset               = 1'b1;
        hsel                = 1'b0;
        haddr               = 32'h0;
        htrans              = 2'b00;
        hwrite              = 1'b0;
        hwdata              = 32'h0;
        clear_instr         = 1'b0;
        halt_instr          = 1'b0;
        low_power_mode      = 1'b0;
        external_init_pin_n = 1'b1;
        mismatches          = 0;
        tests_run           = 0;
        cycles              = 0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_power_on();
        t_overflow_run();
        t_halt_sleep();
        t_clear_and_disable();
        t_key_fault();
        t_pin_reset();
        summarize();
    end

endmodule // watchdog_and_reset_control_tb_top
